// File: rtl/csd_defs.svh
`ifndef CSD_DEFS_SVH
`define CSD_DEFS_SVH

// register offsets
`define CSD_ADDR_CHG_DETAIL 8'hB4
`define CSD_ADDR_BYP_DETAIL 8'hB5
`define CSD_REG_RESET 8'h00

// charger_state_detail field positions
`define CSD_CHG_LSB 0
`define CSD_CHG_MSB 3
`define CSD_BAT_LSB 4
`define CSD_BAT_MSB 6
`define CSD_FOLDBACK_BIT 7

// charge_state_code values
`define CSD_CHG_PREQUAL 4'h0
`define CSD_CHG_FAST_CC 4'h1
`define CSD_CHG_FAST_CV 4'h2
`define CSD_CHG_TOPOFF 4'h3
`define CSD_CHG_TOPOFF_DONE 4'h4
`define CSD_CHG_DONE 4'h5
`define CSD_CHG_TIMER_FAULT 4'h6
`define CSD_CHG_DETECT_SUSP 4'h7
`define CSD_CHG_OFF 4'h8
`define CSD_CHG_THERM_SHDN 4'hA
`define CSD_CHG_WDOG 4'hC

// battery_state_code values
`define CSD_BAT_NONE 3'h0
`define CSD_BAT_PREQUAL 3'h1
`define CSD_BAT_TIMER 3'h2
`define CSD_BATTERY_HEALTHY 3'h3
`define CSD_BAT_LOW 3'h4
`define CSD_BAT_OVERVOLT 3'h5
`define CSD_BAT_OVERCURR 3'h6

// timing: overvoltage code hold after the battery drops below threshold
`define CSD_CLK_PERIOD_NS 10
`define CSD_OV_HOLD_US 37500
`define CSD_OV_HOLD_CYC ((`CSD_OV_HOLD_US * 1000) / `CSD_CLK_PERIOD_NS)

`endif

// File: rtl/csd_pkg.sv
package csd_pkg;
    typedef logic [3:0] csd_chg_code_t;
    typedef logic [2:0] csd_bat_code_t;
    typedef logic [3:0] csd_byp_bits_t;
endpackage

// File: rtl/csd_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for a bundle of independent analog status levels
module csd_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
    logic [WIDTH-1:0] nxt_meta;
    logic [WIDTH-1:0] nxt_sync;

    // next values: first stage only feeds the second
    always_comb
    begin
        nxt_meta = asyncIn;
        nxt_sync = meta_ff;
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else
        begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign syncOut = sync_ff;
endmodule

// File: rtl/csd_ov_hold.sv
`timescale 1ns/1ps
`include "csd_defs.svh"
// stretches the overvoltage condition for a fixed hold after it clears
module csd_ov_hold #(
    parameter int HOLD_CYC = `CSD_OV_HOLD_CYC
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic ovRaw,
    output logic ovHeld
);
    localparam int CW = $clog2(HOLD_CYC + 1);
    logic [CW-1:0] holdCnt_ff;
    logic [CW-1:0] nxt_holdCnt;

    // reload while over threshold, count down afterwards
    always_comb
    begin
        if (ovRaw)
            nxt_holdCnt = CW'(HOLD_CYC);
        else if (holdCnt_ff != '0)
            nxt_holdCnt = holdCnt_ff - CW'(1);
        else
            nxt_holdCnt = holdCnt_ff;
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            holdCnt_ff <= '0;
        else
            holdCnt_ff <= nxt_holdCnt;
    end

    assign ovHeld = ovRaw | (holdCnt_ff != '0);

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    AST_OV_HOLD_STRETCH: assert property ($fell(ovRaw) |-> ovHeld [*2])
        else $error("overvoltage hold dropped too early");
    AST_OV_HOLD_END: assert property (!ovRaw && holdCnt_ff == CW'(1) |=> !ovRaw |-> !ovHeld)
        else $error("overvoltage hold did not expire");
    COV_OV_HOLD_EXPIRE: cover property ($fell(ovHeld));
endmodule

// File: rtl/csd_status_regs.sv
`timescale 1ns/1ps
`include "csd_defs.svh"
module csd_status_regs #(
    parameter int OV_HOLD_CYC = `CSD_OV_HOLD_CYC
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic dieOverShutdown,
    input wire logic watchdogExpired,
    input wire logic chargerOff,
    input wire logic battery_detect_input,
    input wire logic timerFault,
    input wire logic topOffAboveRestart,
    input wire logic topOffActive,
    input wire logic fastCvActive,
    input wire logic fastCcActive,
    input wire logic batBelowPrequal,
    input wire logic batAboveSysMin,
    input wire logic batNoBattery,
    input wire logic batOverCurrent,
    input wire logic batOverThreshold,
    input wire logic inputValid,
    input wire logic boostActive,
    input wire logic dieOverRegulation,
    input wire logic otg_current_limit_hit,
    input wire logic boost_current_limit_hit,
    input wire logic buck_reverse_current_limit_hit,
    input wire logic regRdEn,
    input wire logic [7:0] regAddr,
    output logic [7:0] regRdData,
    output logic regRdValid,
    output logic bypass_change_irq,
    output logic charger_healthy,
    output logic battery_healthy,
    output logic bypass_healthy
);
    localparam int NSYNC = 20;

    ////////////////////////////////////////////////////////////////////////////
    // encoders

    // charge state: highest-severity condition wins, never a reserved code
    function automatic csd_pkg::csd_chg_code_t encChg(input logic [NSYNC-1:0] s);
        if (s[0])
            encChg = `CSD_CHG_THERM_SHDN;
        else if (s[1])
            encChg = `CSD_CHG_WDOG;
        else if (s[2])
            encChg = `CSD_CHG_OFF;
        else if (s[3])
            encChg = `CSD_CHG_DETECT_SUSP;
        else if (s[4])
            encChg = `CSD_CHG_TIMER_FAULT;
        else if (s[5])
            encChg = `CSD_CHG_TOPOFF_DONE;
        else if (s[6])
            encChg = `CSD_CHG_TOPOFF;
        else if (s[7])
            encChg = `CSD_CHG_FAST_CV;
        else if (s[8])
            encChg = `CSD_CHG_FAST_CC;
        else if (s[9])
            encChg = `CSD_CHG_PREQUAL;
        else
            encChg = `CSD_CHG_OFF;
    endfunction

    // battery state with fault priority
    function automatic csd_pkg::csd_bat_code_t encBat(input logic [NSYNC-1:0] s, input logic ov);
        if (s[12])
            encBat = `CSD_BAT_OVERCURR;
        else if (s[11])
            encBat = `CSD_BAT_NONE;
        else if (ov)
            encBat = `CSD_BAT_OVERVOLT;
        else if (s[4])
            encBat = `CSD_BAT_TIMER;
        else if (s[9])
            encBat = `CSD_BAT_PREQUAL;
        else if (s[10])
            encBat = `CSD_BATTERY_HEALTHY;
        else
            encBat = `CSD_BAT_LOW;
    endfunction

    // charger healthy decode of a charge code
    function automatic logic chgHealthy(input csd_pkg::csd_chg_code_t c);
        chgHealthy = (c == `CSD_CHG_PREQUAL) || (c == `CSD_CHG_FAST_CC) || (c == `CSD_CHG_FAST_CV) ||
                     (c == `CSD_CHG_TOPOFF) || (c == `CSD_CHG_DONE) || (c == `CSD_CHG_OFF);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // input synchronisation and overvoltage hold

    logic [NSYNC-1:0] syn;
    logic ovRaw;
    logic ovHeld;

    csd_sync #(
        .WIDTH(NSYNC)
    ) u_sync (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .asyncIn({buck_reverse_current_limit_hit, boost_current_limit_hit, otg_current_limit_hit,
                  dieOverRegulation, boostActive, inputValid, batOverThreshold, batOverCurrent,
                  batNoBattery, batAboveSysMin, batBelowPrequal, fastCcActive, fastCvActive,
                  topOffActive, topOffAboveRestart, timerFault, battery_detect_input, chargerOff,
                  watchdogExpired, dieOverShutdown}),
        .syncOut(syn)
    );

    // overvoltage only counts with a valid input or while boosting
    assign ovRaw = syn[13] & (syn[14] | syn[15]);

    csd_ov_hold #(
        .HOLD_CYC(OV_HOLD_CYC)
    ) u_ov_hold (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .ovRaw(ovRaw),
        .ovHeld(ovHeld)
    );

    ////////////////////////////////////////////////////////////////////////////
    // status registers

    csd_pkg::csd_chg_code_t chgCode_ff;
    csd_pkg::csd_chg_code_t nxt_chgCode;
    csd_pkg::csd_bat_code_t batCode_ff;
    csd_pkg::csd_bat_code_t nxt_batCode;
    logic foldback_ff;
    logic nxt_foldback;
    csd_pkg::csd_byp_bits_t bypBits_ff;
    csd_pkg::csd_byp_bits_t nxt_bypBits;
    logic irq_ff;
    logic nxt_irq;
    logic chgOk_ff;
    logic nxt_chgOk;
    logic batOk_ff;
    logic nxt_batOk;
    logic bypOk_ff;
    logic nxt_bypOk;

    // next status values from synchronised conditions
    always_comb
    begin
        nxt_chgCode = encChg(syn);
        nxt_batCode = encBat(syn, ovHeld);
        nxt_foldback = syn[16];
        nxt_bypBits = {1'b0, syn[19], syn[18], syn[17]};
        nxt_irq = (nxt_bypBits != bypBits_ff);
        nxt_chgOk = chgHealthy(nxt_chgCode);
        nxt_batOk = (nxt_batCode == `CSD_BATTERY_HEALTHY) || (nxt_batCode == `CSD_BAT_LOW);
        nxt_bypOk = (nxt_bypBits == '0);
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            chgCode_ff <= '0;
            batCode_ff <= '0;
            foldback_ff <= 1'b0;
            bypBits_ff <= '0;
            irq_ff <= 1'b0;
            chgOk_ff <= 1'b0;
            batOk_ff <= 1'b0;
            bypOk_ff <= 1'b0;
        end
        else
        begin
            chgCode_ff <= nxt_chgCode;
            batCode_ff <= nxt_batCode;
            foldback_ff <= nxt_foldback;
            bypBits_ff <= nxt_bypBits;
            irq_ff <= nxt_irq;
            chgOk_ff <= nxt_chgOk;
            batOk_ff <= nxt_batOk;
            bypOk_ff <= nxt_bypOk;
        end
    end

    assign bypass_change_irq = irq_ff;
    assign charger_healthy = chgOk_ff;
    assign battery_healthy = batOk_ff;
    assign bypass_healthy = bypOk_ff;

    ////////////////////////////////////////////////////////////////////////////
    // read port: one-cycle latency, no write path exists

    logic [7:0] rdData_ff;
    logic [7:0] nxt_rdData;
    logic rdValid_ff;
    logic nxt_rdValid;

    // address decode, unmapped or idle reads return zero
    always_comb
    begin
        nxt_rdValid = regRdEn;
        if (!regRdEn)
            nxt_rdData = `CSD_REG_RESET;
        else if (regAddr == `CSD_ADDR_CHG_DETAIL)
            nxt_rdData = {foldback_ff, batCode_ff, chgCode_ff};
        else if (regAddr == `CSD_ADDR_BYP_DETAIL)
            nxt_rdData = {4'h0, bypBits_ff};
        else
            nxt_rdData = `CSD_REG_RESET;
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rdData_ff <= `CSD_REG_RESET;
            rdValid_ff <= 1'b0;
        end
        else
        begin
            rdData_ff <= nxt_rdData;
            rdValid_ff <= nxt_rdValid;
        end
    end

    assign regRdData = rdData_ff;
    assign regRdValid = rdValid_ff;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    AST_THERM_SHDN: assert property (syn[0] |=> chgCode_ff == `CSD_CHG_THERM_SHDN)
        else $error("thermal shutdown code wrong");
    AST_WDOG: assert property (!syn[0] && syn[1] |=> chgCode_ff == `CSD_CHG_WDOG)
        else $error("watchdog code wrong");
    AST_PREQUAL_PAIR: assert property (batCode_ff == `CSD_BAT_PREQUAL |-> chgCode_ff == `CSD_CHG_PREQUAL
                                       || $past(syn[3:0]) != 4'h0 || $past(syn[8:5]) != 4'h0)
        else $error("prequal battery code without prequal charge code");
    AST_TIMER_PAIR: assert property (batCode_ff == `CSD_BAT_TIMER |-> chgCode_ff == `CSD_CHG_TIMER_FAULT
                                     || $past(syn[3:0]) != 4'h0)
        else $error("timer battery code without timer charge code");
    AST_OVERCURR_FIRST: assert property (syn[12] |=> batCode_ff == `CSD_BAT_OVERCURR)
        else $error("overcurrent lost priority");
    AST_NO_BATTERY: assert property (!syn[12] && syn[11] |=> batCode_ff == `CSD_BAT_NONE)
        else $error("missing battery code not reported");
    AST_OV_GATED: assert property (!syn[12] && !syn[11] && syn[13] && (syn[14] || syn[15])
                                   |=> batCode_ff == `CSD_BAT_OVERVOLT)
        else $error("overvoltage code not reported");
    // the read must come while the hot condition still holds, one cycle after it is registered
    AST_FOLDBACK: assert property (syn[16] ##1 (syn[16] && regRdEn && regAddr == `CSD_ADDR_CHG_DETAIL)
                                   |=> regRdData[7])
        else $error("foldback bit not read back");
    AST_BYP_MAP: assert property (bypBits_ff == $past({1'b0, syn[19:17]}))
        else $error("bypass bits not mapped one to one");
    AST_BYP_IRQ: assert property ($changed(bypBits_ff) |-> bypass_change_irq)
        else $error("bypass change without interrupt");
    AST_BYP_IRQ_QUIET: assert property ($stable(bypBits_ff) |-> !bypass_change_irq)
        else $error("spurious bypass interrupt");
    // the first edge after release still shows the reset flags, so the decode is checked from the next
    AST_CHARGER_HEALTHY: assert property ($past(arst_n) |-> charger_healthy == chgHealthy(chgCode_ff))
        else $error("charger healthy mismatch");
    AST_BATTERY_HEALTHY: assert property (battery_healthy == (batCode_ff inside {`CSD_BATTERY_HEALTHY, `CSD_BAT_LOW}))
        else $error("battery healthy mismatch");
    AST_BYPASS_HEALTHY: assert property ($past(arst_n) |-> bypass_healthy == (bypBits_ff == '0))
        else $error("bypass healthy mismatch");
    AST_NO_RSVD: assert property (chgCode_ff != 4'h9 && chgCode_ff != 4'hB && chgCode_ff < 4'hD
                                  && bypBits_ff[3] == 1'b0)
        else $error("reserved code produced");
    AST_UNMAPPED: assert property (regRdEn && regAddr != `CSD_ADDR_CHG_DETAIL && regAddr != `CSD_ADDR_BYP_DETAIL
                                   |=> regRdValid && regRdData == 8'h00)
        else $error("unmapped read not zero");

    COV_BYP_IRQ: cover property (bypass_change_irq);
    COV_OVERVOLT: cover property (batCode_ff == `CSD_BAT_OVERVOLT);
    COV_TOPOFF_DONE: cover property (chgCode_ff == `CSD_CHG_TOPOFF_DONE);
    COV_READ_CHG: cover property (regRdEn && regAddr == `CSD_ADDR_CHG_DETAIL);
endmodule

// File: tb/csd_host_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// host side of the status read port, requests change at the falling edge
module csd_host_model (
    input wire logic ref_clk,
    input wire logic regRdValid,
    input wire logic [7:0] regRdData,
    output logic regRdEn,
    output logic [7:0] regAddr
);
    // idle bus at start
    initial
    begin
        regRdEn = 1'b0;
        regAddr = 8'h00;
    end
    // one read strobe; the answer stands during the next cycle
    task automatic read(input logic [7:0] addr, output logic [7:0] data, output logic valid);
        regRdEn = 1'b1;
        regAddr = addr;
        @(negedge ref_clk);
        data = regRdData;
        valid = regRdValid;
    endtask
    // released address shows the inverse so a stale value cannot match
    task automatic idle();
        regRdEn = 1'b0;
        regAddr = ~regAddr;
    endtask
endmodule

// File: tb/csd_status_regs_tb.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module csd_status_regs_tb;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [19:0] st = 20'h00000;
    logic [7:0] regAddr;
    logic [7:0] regRdData;
    logic regRdEn;
    logic regRdValid;
    logic irq;
    logic chgH;
    logic batH;
    logic bypH;
    logic [15:0] lfsr = 16'h0139;
    int errCount = 0;
    int nChecks = 0;
    int irqCnt = 0;
    int cnt;

    // 100 MHz clock
    always #5 ref_clk = ~ref_clk;

    // count interrupt event cycles
    always @(posedge ref_clk)
        if (irq === 1'b1) irqCnt <= irqCnt + 1;

    ////////////////////////////////////////////////////////////////////////////
    csd_status_regs #(.OV_HOLD_CYC(20)) DUT (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .dieOverShutdown(st[0]),
        .watchdogExpired(st[1]),
        .chargerOff(st[2]),
        .battery_detect_input(st[3]),
        .timerFault(st[4]),
        .topOffAboveRestart(st[5]),
        .topOffActive(st[6]),
        .fastCvActive(st[7]),
        .fastCcActive(st[8]),
        .batBelowPrequal(st[9]),
        .batAboveSysMin(st[10]),
        .batNoBattery(st[11]),
        .batOverCurrent(st[12]),
        .batOverThreshold(st[13]),
        .inputValid(st[14]),
        .boostActive(st[15]),
        .dieOverRegulation(st[16]),
        .otg_current_limit_hit(st[17]),
        .boost_current_limit_hit(st[18]),
        .buck_reverse_current_limit_hit(st[19]),
        .regRdEn(regRdEn),
        .regAddr(regAddr),
        .regRdData(regRdData),
        .regRdValid(regRdValid),
        .bypass_change_irq(irq),
        .charger_healthy(chgH),
        .battery_healthy(batH),
        .bypass_healthy(bypH)
    );

    csd_host_model HOST (
        .ref_clk(ref_clk),
        .regRdValid(regRdValid),
        .regRdData(regRdData),
        .regRdEn(regRdEn),
        .regAddr(regAddr)
    );

    ////////////////////////////////////////////////////////////////////////////
    // expected codes, later lines win so the order is lowest priority first
    function automatic logic [3:0] expChg(input logic [19:0] v);
        logic [3:0] c;
        c = 4'h8;
        if (v[9]) c = 4'h0;
        if (v[8]) c = 4'h1;
        if (v[7]) c = 4'h2;
        if (v[6]) c = 4'h3;
        if (v[5]) c = 4'h4;
        if (v[4]) c = 4'h6;
        if (v[3]) c = 4'h7;
        if (v[2]) c = 4'h8;
        if (v[1]) c = 4'hC;
        if (v[0]) c = 4'hA;
        return c;
    endfunction

    function automatic logic [2:0] expBat(input logic [19:0] v);
        logic [2:0] b;
        b = v[10] ? 3'h3 : 3'h4;
        if (v[9]) b = 3'h1;
        if (v[4]) b = 3'h2;
        if (v[13] && (v[14] || v[15])) b = 3'h5;
        if (v[11]) b = 3'h0;
        if (v[12]) b = 3'h6;
        return b;
    endfunction

    function automatic logic [7:0] expHealth(input logic [19:0] v);
        logic [3:0] c;
        logic [2:0] b;
        c = expChg(v);
        b = expBat(v);
        return {5'h00, c inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h8}, b inside {3'h3, 3'h4}, v[19:17] == 3'h0};
    endfunction

    function automatic logic [15:0] lfsrNext(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // compare and count
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        nChecks++;
        if (seen !== exp)
        begin
            errCount++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic endOfTest();
        $display("checks %0d mismatches %0d", nChecks, errCount);
        if (errCount == 0 && nChecks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // one read at a falling edge, checking valid and data
    task automatic rd(input logic [7:0] addr, input logic [7:0] exp, input string name);
        logic [7:0] d;
        logic v;
        HOST.read(addr, d, v);
        check({name, " valid"}, {7'h00, v}, 8'h01);
        check(name, d, exp);
    endtask

    // settle a status vector, then read both registers and a hole back to back
    task automatic applyAndRead(input logic [19:0] v);
        st = v;
        repeat (30) @(negedge ref_clk);
        rd(8'hB4, {v[16], expBat(v), expChg(v)}, "detail");
        rd(8'hB5, {5'h00, v[19:17]}, "bypass");
        rd(8'hB6, 8'h00, "unmapped");
        HOST.idle();
        @(negedge ref_clk);
        check("health", {5'h00, chgH, batH, bypH}, expHealth(v));
        check("released", regRdData | {7'h00, regRdValid}, 8'h00);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // limit on the whole run
    initial
    begin
        #200000;
        errCount++;
        endOfTest();
    end

    // main sequence
    initial
    begin
        repeat (4) @(negedge ref_clk);
        check("reset health", {5'h00, chgH, batH, bypH}, 8'h00);
        check("reset data", regRdData, 8'h00);
        repeat (4) @(negedge ref_clk);
        arst_n = 1'b1;
        for (int i = 0; i < 20; i++) applyAndRead(20'h00001 << i);
        applyAndRead(20'h0A000);
        applyAndRead(20'hFFFFF);
        $display("sweep and priority done");
        applyAndRead(20'h06000);
        st = 20'h04000;
        repeat (10) @(negedge ref_clk);
        rd(8'hB4, 8'h58, "ov hold");
        HOST.idle();
        applyAndRead(20'h04000);
        $display("overvoltage hold done");
        cnt = irqCnt;
        st = 20'h20000;
        repeat (10) @(negedge ref_clk);
        check("irq set", 8'(irqCnt - cnt), 8'h01);
        st = 20'h00000;
        repeat (10) @(negedge ref_clk);
        check("irq clear", 8'(irqCnt - cnt), 8'h02);
        st = 20'hC0000;
        repeat (10) @(negedge ref_clk);
        check("irq pair", 8'(irqCnt - cnt), 8'h03);
        // reset in mid-run, then the held bypass bits must raise one fresh event
        arst_n = 1'b0;
        @(negedge ref_clk);
        check("mid reset health", {5'h00, chgH, batH, bypH}, 8'h00);
        check("mid reset irq", {7'h00, irq}, 8'h00);
        cnt = irqCnt;
        arst_n = 1'b1;
        repeat (10) @(negedge ref_clk);
        check("irq after reset", 8'(irqCnt - cnt), 8'h01);
        $display("interrupt event done");
        for (int i = 0; i < 40; i++)
        begin
            lfsr = lfsrNext(lfsr);
            cnt = lfsr;
            lfsr = lfsrNext(lfsr);
            applyAndRead({cnt[3:0], lfsr} & {lfsr[7:4], cnt[15:0]});
        end
        $display("random vectors done");
        endOfTest();
    end
endmodule
